/* File: bench/fsu_top_sva.sv */
`timescale 1ns/1ps
module fsu_top_sva
	import fsu_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        instr_valid,
	input wire logic [15:0] instr_word,
	input wire fsu_hreg_s   host_wr,
	input wire logic        rd_file,
	input wire logic [3:0]  rd_idx,
	input wire logic [31:0] rd_data,
	input wire logic [31:0] status_word,
	input wire logic        instr_busy,
	input wire logic        instr_done,
	input wire logic        instr_ignored
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic acc;
	logic is_set_field_params_instr;
	logic is_sign_extend_instr;
	logic is_asl;
	logic is_lsl;
	logic [15:0] w;
	assign w = instr_word;
	assign acc = instr_valid && !instr_busy;
	assign is_set_field_params_instr = w[15:10] == 6'h01 && w[8:6] == 3'h5;
	assign is_sign_extend_instr = w[15:10] == 6'h01 && w[8:5] == 4'h8;
	assign is_asl = w[15:10] == 6'h08 || w[15:9] == 7'h30;
	assign is_lsl = w[15:10] == 6'h09 || w[15:9] == 7'h31;
	sequence s_commit;
		instr_done && !instr_busy;
	endsequence
	sequence s_hold2;
		instr_busy [*2];
	endsequence
	// ----------------------------------------------------------------
	// Timing and status effects
	// ----------------------------------------------------------------
	a_set_field_params_instr_one_state: assert property (acc && is_set_field_params_instr |=> s_commit)
		else $error("field setup timing");
	a_set_field_params_instr_others_kept: assert property (acc && is_set_field_params_instr |=>
		status_word[31:12] == $past(status_word[31:12]))
		else $error("field setup touched other bits");
	a_set_field_params_instr_field_zero: assert property (acc && is_set_field_params_instr && !w[9] |=>
		status_word[11:0] == {$past(status_word[11:6]), $past(w[5:0])})
		else $error("field 0 update wrong");
	a_set_field_params_instr_field_one: assert property (acc && is_set_field_params_instr && w[9] |=>
		status_word[11:0] == {$past(w[5:0]), $past(status_word[5:0])})
		else $error("field 1 update wrong");
	a_sign_extend_instr_two_states: assert property (acc && is_sign_extend_instr |=>
		instr_busy ##1 s_commit)
		else $error("sign extend timing");
	a_sign_extend_instr_keeps_cv: assert property (acc && is_sign_extend_instr |-> ##2
		status_word[30] == $past(status_word[30], 2) &&
		status_word[28] == $past(status_word[28], 2))
		else $error("sign extend changed C or V");
	a_asl_three_states: assert property (acc && is_asl |=>
		s_hold2 ##1 s_commit)
		else $error("arith shift timing");
	a_lsl_one_state: assert property (acc && is_lsl |=> s_commit)
		else $error("logic shift timing");
	a_lsl_keeps_nv: assert property (acc && is_lsl |=>
		status_word[31] == $past(status_word[31]) &&
		status_word[28] == $past(status_word[28]))
		else $error("logic shift changed N or V");
	a_busy_refused: assert property (instr_valid && instr_busy |=>
		instr_ignored)
		else $error("request while busy not refused");
	a_unknown_refused: assert property (acc &&
		!(is_set_field_params_instr || is_sign_extend_instr || is_asl || is_lsl) |=>
		instr_ignored && !instr_done)
		else $error("unknown word not refused");
endmodule : fsu_top_sva

bind fsu_top fsu_top_sva fsu_top_sva_inst (
	.clk_sys(clk_sys), .nrst(nrst), .instr_valid(instr_valid),
	.instr_word(instr_word), .host_wr(host_wr), .rd_file(rd_file),
	.rd_idx(rd_idx), .rd_data(rd_data), .status_word(status_word),
	.instr_busy(instr_busy), .instr_done(instr_done),
	.instr_ignored(instr_ignored)
);

/* File: bench/fsu_top_test.sv */
`timescale 1ns/1ps
module fsu_top_test;
	import fsu_pkg::*;
	typedef struct packed {
		logic [31:0] st;
		logic        chk;
		logic [31:0] val;
	} fsu_exp_s;
	logic        clk_sys;
	logic        nrst;
	logic        instr_valid;
	logic [15:0] instr_word;
	fsu_hreg_s   host_wr;
	logic        rd_file;
	logic [3:0]  rd_idx;
	logic [31:0] rd_data;
	logic [31:0] status_word;
	logic        instr_busy;
	logic        instr_done;
	logic        instr_ignored;
	logic [31:0] regs_m [2][16];
	logic [31:0] st_m;
	logic [31:0] lfsr;
	logic [4:0]  cnt [8] = '{5'h00, 5'h01, 5'h02, 5'h03,
	                         5'h05, 5'h1E, 5'h1F, 5'h10};
	logic [4:0]  fsz [4] = '{5'h0F, 5'h10, 5'h11, 5'h00};
	fsu_exp_s    exp_q [$];
	fsu_exp_s    pend;
	logic        pend_v;
	int          err_total;
	int          tests_run;

	fsu_top fsu_top_inst (
		.clk_sys(clk_sys), .nrst(nrst), .instr_valid(instr_valid),
		.instr_word(instr_word), .host_wr(host_wr), .rd_file(rd_file),
		.rd_idx(rd_idx), .rd_data(rd_data), .status_word(status_word),
		.instr_busy(instr_busy), .instr_done(instr_done),
		.instr_ignored(instr_ignored)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : rnd

	task automatic chk(input string nm, input logic [31:0] e,
	                   input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// Reference model: updates state and notes the expected commit
	task automatic model(input logic [15:0] w);
		fsu_exp_s    e;
		logic [31:0] v;
		logic [31:0] t;
		int          c;
		int          n;
		logic        r;
		logic        lg;
		r = w[4];
		v = regs_m[r][w[3:0]];
		e.chk = 1'b1;
		lg = 1'b0;
		if (w[15:10] == 6'h01 && w[8:6] == 3'h5) begin
			if (w[9]) st_m[11:6] = w[5:0];
			else st_m[5:0] = w[5:0];
			e.chk = 1'b0;
		end else begin
			if (w[15:10] == 6'h01) begin
				n = w[9] ? st_m[10:6] : st_m[4:0];
				if (n == 0) n = 32;
				t = (n == 32) ? 32'h0000_0000 : (FSU_ALL1 << n);
				v = v[n - 1] ? (v | t) : (v & ~t);
			end else begin
				// Bit 14 tells the register-count forms from the immediate ones
				lg = w[14] ? w[9] : w[10];
				c = w[14] ? int'(regs_m[r][w[8:5]][4:0]) : int'(w[9:5]);
				t = v >> (31 - c);
				st_m[30] = (c == 0) ? 1'b0 : v[32 - c];
				if (!lg) st_m[28] = !(t == 0 || t == (FSU_ALL1 >> (31 - c)));
				v = v << c;
			end
			if (!lg) st_m[31] = v[31];
			st_m[29] = (v == 32'h0000_0000);
			regs_m[r][w[3:0]] = v;
		end
		e.st = st_m;
		e.val = v;
		exp_q.push_back(e);
	endtask : model

	task automatic drv(input logic [15:0] w, input logic m);
		if (m) model(w);
		instr_valid = 1'b1;
		instr_word = w;
		rd_file = w[4];
		rd_idx = w[3:0];
	endtask : drv

	task automatic iss(input logic [15:0] w);
		int n;
		n = 0;
		@(posedge clk_sys);
		#1 drv(w, 1'b1);
		@(posedge clk_sys);
		#1 instr_valid = 1'b0;
		while (instr_busy === 1'b1 && n < 10) begin
			@(posedge clk_sys);
			#1 n++;
		end
		if (n >= 10) chk("instr_busy", 32'h0, 32'h1);
	endtask : iss

	task automatic hw(input logic r, input logic [3:0] i, input logic [31:0] d);
		@(posedge clk_sys);
		#1 host_wr = '{wr: 1'b1, file: r, idx: i, data: d};
		regs_m[r][i] = d;
		@(posedge clk_sys);
		#1 host_wr = '{wr: 1'b0, file: ~r, idx: ~i, data: ~d};
	endtask : hw

	// ----------------------------------------------------------------
	// Clock, watchdog and result monitor
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		#100000;
		err_total++;
		end_of_test();
	end

	always @(posedge clk_sys) begin
		#2;
		if (pend_v) chk("rd_data", pend.val, rd_data);
		pend_v = 1'b0;
		if (instr_done === 1'b1) begin
			if (exp_q.size() == 0) chk("instr_done", 32'h0, 32'h1);
			else begin
				pend = exp_q.pop_front();
				chk("status_word", pend.st, status_word);
				pend_v = pend.chk;
			end
		end
	end

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		host_wr = '0;
		rd_file = 1'b0;
		rd_idx = 4'h0;
		lfsr = 32'h0000_005B;
		err_total = 0;
		tests_run = 0;
		pend_v = 1'b0;
		st_m = FSU_ST_RST;
		foreach (regs_m[i, j]) regs_m[i][j] = FSU_REG_RST;
		repeat (16) @(posedge clk_sys);
		#1 nrst = 1'b1;
		for (int i = 0; i < 16; i++)
			iss({6'h01, i[0], 3'h5, i[1], fsz[i[3:2]]});
		$display("test field_setup done");
		for (int i = 0; i < 8; i++) begin
			lfsr = rnd(lfsr);
			hw(i[0], 4'h0, i[0] ? 32'h0000_8000 : lfsr);
			iss({6'h01, i[0], 3'h5, 1'b0, fsz[i[2:1]]});
			iss({6'h01, i[0], 4'h8, i[0], 4'h0});
		end
		$display("test sign_extend done");
		for (int i = 0; i < 32; i++) begin
			lfsr = rnd(lfsr);
			hw(i[0], 4'h5, (i[2:0] < 3'h4) ? 32'hCCCC_CCCC : lfsr);
			iss({5'h04, i[4], cnt[i[3:1]], i[0], 4'h5});
		end
		$display("test imm_shift done");
		for (int i = 0; i < 16; i++) begin
			lfsr = rnd(lfsr);
			hw(i[0], 4'h3, lfsr);
			hw(i[0], 4'hA, lfsr ^ 32'h8888_8888);
			iss({6'h18, i[1], 4'h3, i[0], 4'hA});
		end
		$display("test reg_shift done");
		hw(1'b1, 4'h6, 32'h8888_8888);
		@(posedge clk_sys);
		#1 drv({6'h09, 5'h01, 1'b1, 4'h6}, 1'b1);
		@(posedge clk_sys);
		#1 drv({6'h09, 5'h04, 1'b1, 4'h6}, 1'b1);
		@(posedge clk_sys);
		#1 drv({6'h08, 5'h02, 1'b1, 4'h6}, 1'b1);
		@(posedge clk_sys);
		#1 drv({6'h09, 5'h03, 1'b1, 4'h6}, 1'b0);
		@(posedge clk_sys);
		#1 instr_valid = 1'b0;
		chk("instr_ignored", 32'h1, {31'h0, instr_ignored});
		repeat (3) @(posedge clk_sys);
		#1 drv(16'hFFFF, 1'b0);
		@(posedge clk_sys);
		#1 instr_valid = 1'b0;
		chk("instr_ignored", 32'h1, {31'h0, instr_ignored});
		repeat (4) @(posedge clk_sys);
		chk("pending", 32'h0, exp_q.size());
		$display("test back_to_back done");
		end_of_test();
	end
endmodule : fsu_top_test

/* File: logic/fsu_pkg.sv */
package fsu_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int          FSU_DW    = 32;
	localparam int          FSU_NREG  = 16;
	localparam int          FSU_NFILE = 2;
	localparam logic [31:0] FSU_ALL1  = 32'hFFFF_FFFF;

	// ----------------------------------------------------------------
	// Status word layout and reset value
	// ----------------------------------------------------------------
	localparam int          FSU_ST_N       = 31;
	localparam int          FSU_ST_C       = 30;
	localparam int          FSU_ST_Z       = 29;
	localparam int          FSU_ST_V       = 28;
	localparam int          FSU_ST_FS0_LSB = 0;
	localparam int          FSU_ST_FE0     = 5;
	localparam int          FSU_ST_FS1_LSB = 6;
	localparam int          FSU_ST_FE1     = 11;
	localparam int          FSU_FLD_W      = 6;
	localparam logic [31:0] FSU_ST_RST     = 32'h0000_0000;
	localparam logic [5:0]  FSU_FS_FULL    = 6'h20;
	localparam logic [31:0] FSU_REG_RST    = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Opcode fields
	// ----------------------------------------------------------------
	localparam logic [5:0] FSU_OPC_FLD   = 6'h01;
	localparam logic [2:0] FSU_SET_FIELD_PARAMS_INSTR_MID  = 3'h5;
	localparam logic [3:0] FSU_SIGN_EXTEND_INSTR_MID  = 4'h8;
	localparam logic [5:0] FSU_OPC_ASL_I = 6'h08;
	localparam logic [5:0] FSU_OPC_LSL_I = 6'h09;
	localparam logic [6:0] FSU_OPC_ASL_R = 7'h30;
	localparam logic [6:0] FSU_OPC_LSL_R = 7'h31;

	// ----------------------------------------------------------------
	// Machine states per instruction
	// ----------------------------------------------------------------
	localparam logic [1:0] FSU_MS_SET_FIELD_PARAMS_INSTR = 2'h1;
	localparam logic [1:0] FSU_MS_SIGN_EXTEND_INSTR = 2'h2;
	localparam logic [1:0] FSU_MS_ASL  = 2'h3;
	localparam logic [1:0] FSU_MS_LSL  = 2'h1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		FSU_OP_NONE = 5'b00001,
		FSU_OP_SET_FIELD_PARAMS_INSTR = 5'b00010,
		FSU_OP_SIGN_EXTEND_INSTR = 5'b00100,
		FSU_OP_ASL  = 5'b01000,
		FSU_OP_LSL  = 5'b10000
	} fsu_op_e;

	typedef enum logic [1:0] {
		FSU_ST_IDLE = 2'b01,
		FSU_ST_RUN  = 2'b10
	} fsu_state_e;

	typedef struct packed {
		fsu_op_e    op;
		logic       use_reg;
		logic       file;
		logic [3:0] rd;
		logic [3:0] rs;
		logic [4:0] cnt;
		logic       f;
		logic       fe;
		logic [4:0] fs;
	} fsu_dec_s;

	typedef struct packed {
		logic        vld;
		logic        wr;
		logic        file;
		logic [3:0]  idx;
		logic [31:0] data;
		logic [31:0] st;
	} fsu_wb_s;

	typedef struct packed {
		logic        wr;
		logic        file;
		logic [3:0]  idx;
		logic [31:0] data;
	} fsu_hreg_s;

endpackage : fsu_pkg

/* File: logic/fsu_top.sv */
`timescale 1ns/1ps

// Summary of operation
// - Field setup writes size and extension into one field slot only.
// - Encoded field size zero means a 32-bit field.
// - Extension bit is stored in the slot but unused; sign extend always copies the field MSB.
// - Field select 0 updates field 0, 1 updates field 1.
// - Field setup takes one state and keeps N, C, Z, V.
// - Sign extend copies field MSB upward; width from selected field size.
// - Sign extend takes two states, sets N and Z, keeps C, V.
// - Immediate arithmetic left shift by 0..31, zeros enter at bottom.
// - Carry gets bit 32 minus count; cleared for count zero.
// - Overflow set when new sign or shifted-out bits differ from sign.
// - Arithmetic left shift takes three states, sets N and Z.
// - Register-count shifts use the low five source bits only.
// - Logical shift like arithmetic, keeps V and N, one state.
module fsu_top
	import fsu_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	input  wire fsu_hreg_s   host_wr,
	input  wire logic        rd_file,
	input  wire logic [3:0]  rd_idx,
	output logic [31:0]      rd_data,
	output logic [31:0]      status_word,
	output logic             instr_busy,
	output logic             instr_done,
	output logic             instr_ignored
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0] regs_ff     [FSU_NFILE][FSU_NREG];
	logic [31:0] nxt_regs    [FSU_NFILE][FSU_NREG];
	logic [31:0] status_ff;
	logic [31:0] nxt_status;
	logic [31:0] rd_data_ff;
	logic [31:0] nxt_rd_data;
	fsu_state_e  state_ff;
	fsu_state_e  nxt_state;
	logic [1:0]  cnt_ff;
	logic [1:0]  nxt_cnt;
	fsu_wb_s     pend_ff;
	fsu_wb_s     nxt_pend;
	logic        busy_ff;
	logic        nxt_busy;
	logic        done_ff;
	logic        nxt_done;
	logic        ign_ff;
	logic        nxt_ign;

	fsu_dec_s    dec;
	fsu_wb_s     wb_now;
	fsu_wb_s     commit;
	logic [1:0]  ms_now;
	logic [31:0] dst;
	logic [31:0] src;
	logic [4:0]  sh;
	logic [31:0] shl;
	logic [5:0]  cidx;
	logic        carry;
	logic [31:0] top;
	logic [31:0] tmask;
	logic        ovf;
	logic [4:0]  fsel;
	logic [5:0]  width;
	logic [5:0]  wm1;
	logic [31:0] lowm;
	logic [31:0] sx;
	logic [31:0] st;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		dec         = '0;
		dec.op      = FSU_OP_NONE;
		dec.file    = instr_word[4];
		dec.rd      = instr_word[3:0];
		dec.rs      = instr_word[8:5];
		dec.cnt     = instr_word[9:5];
		dec.f       = instr_word[9];
		dec.fe      = instr_word[5];
		dec.fs      = instr_word[4:0];
		if (instr_word[15:10] == FSU_OPC_FLD &&
		    instr_word[8:6] == FSU_SET_FIELD_PARAMS_INSTR_MID) begin
			dec.op = FSU_OP_SET_FIELD_PARAMS_INSTR;
		end else if (instr_word[15:10] == FSU_OPC_FLD &&
		             instr_word[8:5] == FSU_SIGN_EXTEND_INSTR_MID) begin
			dec.op = FSU_OP_SIGN_EXTEND_INSTR;
		end else if (instr_word[15:10] == FSU_OPC_ASL_I) begin
			dec.op = FSU_OP_ASL;
		end else if (instr_word[15:10] == FSU_OPC_LSL_I) begin
			dec.op = FSU_OP_LSL;
		end else if (instr_word[15:9] == FSU_OPC_ASL_R) begin
			dec.op      = FSU_OP_ASL;
			dec.use_reg = 1'b1;
		end else if (instr_word[15:9] == FSU_OPC_LSL_R) begin
			dec.op      = FSU_OP_LSL;
			dec.use_reg = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Execute
	// ----------------------------------------------------------------
	always_comb begin
		// Source and destination share the single file bit
		dst   = regs_ff[dec.file][dec.rd];
		src   = regs_ff[dec.file][dec.rs];
		sh    = dec.use_reg ? src[4:0] : dec.cnt;
		shl   = dst << sh;
		cidx  = 6'h20 - {1'b0, sh};
		carry = (sh == 5'h00) ? 1'b0 : dst[cidx[4:0]];
		// Top sh+1 bits: shifted-out bits plus the new sign bit
		top   = dst >> (5'h1F - sh);
		tmask = FSU_ALL1 >> (5'h1F - sh);
		ovf   = (top != 32'h0000_0000) && (top != tmask);
		fsel  = dec.f ? status_ff[FSU_ST_FS1_LSB +: 5]
		              : status_ff[FSU_ST_FS0_LSB +: 5];
		width = (fsel == 5'h00) ? FSU_FS_FULL : {1'b0, fsel};
		wm1   = width - 6'h01;
		lowm  = FSU_ALL1 >> (6'h20 - width);
		sx    = dst[wm1[4:0]] ? (dst | ~lowm) : (dst & lowm);
		st          = status_ff;
		ms_now      = FSU_MS_SET_FIELD_PARAMS_INSTR;
		wb_now      = '0;
		wb_now.file = dec.file;
		wb_now.idx  = dec.rd;
		case (dec.op)
			FSU_OP_SET_FIELD_PARAMS_INSTR: begin
				// Only the chosen slot changes; flags kept
				if (dec.f) begin
					st[FSU_ST_FS1_LSB +: FSU_FLD_W] = {dec.fe, dec.fs};
				end else begin
					st[FSU_ST_FS0_LSB +: FSU_FLD_W] = {dec.fe, dec.fs};
				end
				ms_now = FSU_MS_SET_FIELD_PARAMS_INSTR;
			end
			FSU_OP_SIGN_EXTEND_INSTR: begin
				wb_now.wr   = 1'b1;
				wb_now.data = sx;
				st[FSU_ST_N] = sx[31];
				st[FSU_ST_Z] = (sx == 32'h0000_0000);
				ms_now = FSU_MS_SIGN_EXTEND_INSTR;
			end
			FSU_OP_ASL: begin
				wb_now.wr   = 1'b1;
				wb_now.data = shl;
				st[FSU_ST_N] = shl[31];
				st[FSU_ST_C] = carry;
				st[FSU_ST_Z] = (shl == 32'h0000_0000);
				st[FSU_ST_V] = ovf;
				ms_now = FSU_MS_ASL;
			end
			FSU_OP_LSL: begin
				wb_now.wr   = 1'b1;
				wb_now.data = shl;
				st[FSU_ST_C] = carry;
				st[FSU_ST_Z] = (shl == 32'h0000_0000);
				ms_now = FSU_MS_LSL;
			end
			default: begin
			end
		endcase
		wb_now.vld = (dec.op != FSU_OP_NONE);
		wb_now.st  = st;
	end

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_pend  = pend_ff;
		nxt_ign   = 1'b0;
		commit    = '0;
		case (state_ff)
			FSU_ST_IDLE: begin
				if (instr_valid && wb_now.vld) begin
					if (ms_now == 2'h1) begin
						commit = wb_now;
					end else begin
						nxt_pend  = wb_now;
						nxt_cnt   = ms_now - 2'h1;
						nxt_state = FSU_ST_RUN;
					end
				end else if (instr_valid) begin
					nxt_ign = 1'b1;
				end
			end
			FSU_ST_RUN: begin
				nxt_ign = instr_valid;
				if (cnt_ff == 2'h1) begin
					commit    = pend_ff;
					nxt_state = FSU_ST_IDLE;
				end else begin
					nxt_cnt = cnt_ff - 2'h1;
				end
			end
			default: begin
				nxt_state = FSU_ST_IDLE;
			end
		endcase
		nxt_busy = (nxt_state == FSU_ST_RUN);
		nxt_done = commit.vld;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_ff <= FSU_ST_IDLE;
			cnt_ff   <= 2'h0;
			pend_ff  <= '0;
			busy_ff  <= 1'b0;
			done_ff  <= 1'b0;
			ign_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			pend_ff  <= nxt_pend;
			busy_ff  <= nxt_busy;
			done_ff  <= nxt_done;
			ign_ff   <= nxt_ign;
		end
	end

	// ----------------------------------------------------------------
	// Register files and status word
	// ----------------------------------------------------------------
	always_comb begin
		nxt_regs   = regs_ff;
		nxt_status = status_ff;
		// Commit is written last so it wins over a host write
		if (host_wr.wr) begin
			nxt_regs[host_wr.file][host_wr.idx] = host_wr.data;
		end
		if (commit.vld && commit.wr) begin
			nxt_regs[commit.file][commit.idx] = commit.data;
		end
		if (commit.vld) begin
			nxt_status = commit.st;
		end
		nxt_rd_data = regs_ff[rd_file][rd_idx];
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int f = 0; f < FSU_NFILE; f++) begin
				for (int r = 0; r < FSU_NREG; r++) begin
					regs_ff[f][r] <= FSU_REG_RST;
				end
			end
			status_ff  <= FSU_ST_RST;
			rd_data_ff <= 32'h0000_0000;
		end else begin
			regs_ff    <= nxt_regs;
			status_ff  <= nxt_status;
			rd_data_ff <= nxt_rd_data;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rd_data       = rd_data_ff;
	assign status_word   = status_ff;
	assign instr_busy    = busy_ff;
	assign instr_done    = done_ff;
	assign instr_ignored = ign_ff;

endmodule : fsu_top
